// ### vdic_regs.svh
// Register offsets, field positions, reset values and codes of the
// input configuration bank.
// Assumes it is included by bare name from files that need it.
`ifndef VDIC_REGS_SVH
`define VDIC_REGS_SVH

// ==========================================================================
// Subaddresses
`define VDIC_OFS_FMT_STD        8'h00
`define VDIC_OFS_VPROC          8'h01

// ==========================================================================
// Reset values
`define VDIC_RST_FMT_STD        8'h00
`define VDIC_RST_VPROC          8'hc8

// ==========================================================================
// Field positions
`define VDIC_FMT_MSB            3
`define VDIC_FMT_LSB            0
`define VDIC_STD_MSB            7
`define VDIC_STD_LSB            4
`define VDIC_VSYNC_EN_BIT       3
`define VDIC_PRO_COMP_BIT       5
`define VDIC_HSYNC_EN_BIT       6
`define VDIC_AUTO_PAL_N_BIT     1
`define VDIC_AUTO_PED_BIT       0

// ==========================================================================
// Field codes
`define VDIC_CODE_COMPOSITE     4'h0
`define VDIC_CODE_LUMA_CHROMA   4'h6
`define VDIC_CODE_COMPONENT     4'h9
`define VDIC_STD_FORCED_MIN     4'h4
`define VDIC_STD_ENUM_OFFSET    4'h3

// ==========================================================================
// Serial bus framing
`define VDIC_ACK_SLOT           4'h8
`define VDIC_ACK_END            4'h9
`define VDIC_BYTE_MSB           7
`define VDIC_IDLE_BYTE          8'h00
`define VDIC_SUB_STEP           8'h01

`endif

// ### vdic_pkg.sv
// Types shared by the input configuration bank and its serial port.
// Assumes nothing of its surroundings.
`default_nettype none

package vdic_pkg;
    // Decoded analog input format
    typedef enum logic [1:0] {
        VDIC_FMT_COMPOSITE,
        VDIC_FMT_LUMA_CHROMA,
        VDIC_FMT_COMPONENT,
        VDIC_FMT_UNDEFINED
    } vdic_fmt_e;

    // Colour standard; forced codes follow the auto entry in code order
    typedef enum logic [3:0] {
        VDIC_STD_AUTO,
        VDIC_STD_NTSC_J,
        VDIC_STD_NTSC_M,
        VDIC_STD_PAL_60,
        VDIC_STD_NTSC_443,
        VDIC_STD_PAL_BGHID,
        VDIC_STD_PAL_N,
        VDIC_STD_PAL_M_NOPED,
        VDIC_STD_PAL_M,
        VDIC_STD_PAL_CN,
        VDIC_STD_PAL_CN_PED,
        VDIC_STD_SECAM,
        VDIC_STD_SECAM_PED
    } vdic_std_e;

    // Serial slave phases
    typedef enum logic [2:0] {
        VDIC_SL_IDLE,
        VDIC_SL_ADDR,
        VDIC_SL_SUB,
        VDIC_SL_WRITE,
        VDIC_SL_READ
    } vdic_sl_e;
endpackage : vdic_pkg

`default_nettype wire

// ### vdic_serial_slave.sv
// Two-wire serial slave: device address, subaddress, auto-increment
// writes and reads.
// Assumes scl/sda are already synchronous to ref_clk_in and slow
// against it; sda is open drain, resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "vdic_regs.svh"

module vdic_serial_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h20   // Arbitrary bus address
) (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       arst_n_in,
    // Serial pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    // Register side
    output logic            wr_stb_out,
    output logic [7:0]      sub_addr_out,
    output logic [7:0]      wr_data_out,
    input  wire logic [7:0] rd_data_in
);
    import vdic_pkg::*;

    // ======================================================================
    // State
    vdic_sl_e    st_r,   st_nxt;     // Transfer phase
    logic [3:0]  cnt_r,  cnt_nxt;    // Bit slot, 8 = ack slot
    logic [7:0]  sh_r,   sh_nxt;     // Receive shifter
    logic [7:0]  tx_r,   tx_nxt;     // Transmit shifter
    logic [7:0]  sub_r,  sub_nxt;    // Subaddress pointer
    logic        oe_r,   oe_nxt;     // Pulling sda low
    logic        stb_r,  stb_nxt;    // Write strobe
    logic [7:0]  wd_r,   wd_nxt;     // Written byte
    logic [7:0]  wa_r,   wa_nxt;     // Address of written byte
    logic        scl_q_r;            // Previous scl
    logic        sda_q_r;            // Previous sda
    logic        rise, fall, start, stop;

    // ======================================================================
    // Line events
    assign rise  = scl_in & ~scl_q_r;
    assign fall  = ~scl_in & scl_q_r;
    assign start = scl_in & scl_q_r & sda_q_r & ~sda_in;
    assign stop  = scl_in & scl_q_r & ~sda_q_r & sda_in;

    // Next-state computation
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        sh_nxt  = sh_r;
        tx_nxt  = tx_r;
        sub_nxt = sub_r;
        oe_nxt  = oe_r;
        stb_nxt = 1'b0;
        wd_nxt  = wd_r;
        wa_nxt  = wa_r;
        if (start) begin
            // Start or repeated start restarts address phase
            st_nxt  = VDIC_SL_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end else if (stop) begin
            st_nxt  = VDIC_SL_IDLE;
            oe_nxt  = 1'b0;
        end else if (st_r != VDIC_SL_IDLE && rise) begin
            if (cnt_r < `VDIC_ACK_SLOT) begin
                sh_nxt = {sh_r[6:0], sda_in};
            end else if (st_r == VDIC_SL_READ && !oe_r) begin
                // Only the master's ack slot counts: during our own ack of
                // the address byte we pull sda low, which looks like an ack.
                // Master nack ends the read burst
                if (sda_in) begin
                    st_nxt = VDIC_SL_IDLE;
                end else begin
                    sub_nxt = sub_r + `VDIC_SUB_STEP;
                end
            end
            cnt_nxt = cnt_r + 4'h1;
        end else if (st_r != VDIC_SL_IDLE && fall) begin
            if (cnt_r == `VDIC_ACK_SLOT) begin
                oe_nxt = 1'b1;
                case (st_r)
                    VDIC_SL_ADDR: begin
                        if (sh_r[7:1] == DEV_ADDR) begin
                            st_nxt = sh_r[0] ? VDIC_SL_READ : VDIC_SL_SUB;
                        end else begin
                            st_nxt = VDIC_SL_IDLE;
                            oe_nxt = 1'b0;
                        end
                    end
                    VDIC_SL_SUB: begin
                        sub_nxt = sh_r;
                        st_nxt  = VDIC_SL_WRITE;
                    end
                    VDIC_SL_WRITE: begin
                        stb_nxt = 1'b1;
                        wd_nxt  = sh_r;
                        wa_nxt  = sub_r;
                        sub_nxt = sub_r + `VDIC_SUB_STEP;
                    end
                    VDIC_SL_READ: begin
                        // Master owns the ack slot of a read byte
                        oe_nxt = 1'b0;
                    end
                    default: begin
                        st_nxt = VDIC_SL_IDLE;
                        oe_nxt = 1'b0;
                    end
                endcase
            end else if (cnt_r == `VDIC_ACK_END) begin
                cnt_nxt = 4'h0;
                oe_nxt  = 1'b0;
                if (st_r == VDIC_SL_READ) begin
                    tx_nxt = rd_data_in;
                    oe_nxt = ~rd_data_in[`VDIC_BYTE_MSB];
                end
            end else if (st_r == VDIC_SL_READ) begin
                tx_nxt = {tx_r[6:0], 1'b0};
                oe_nxt = ~tx_r[6];
            end
        end
    end

    // Registers
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r    <= VDIC_SL_IDLE;
            cnt_r   <= 4'h0;
            sh_r    <= `VDIC_IDLE_BYTE;
            tx_r    <= `VDIC_IDLE_BYTE;
            sub_r   <= `VDIC_IDLE_BYTE;
            oe_r    <= 1'b0;
            stb_r   <= 1'b0;
            wd_r    <= `VDIC_IDLE_BYTE;
            wa_r    <= `VDIC_IDLE_BYTE;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            tx_r    <= tx_nxt;
            sub_r   <= sub_nxt;
            oe_r    <= oe_nxt;
            stb_r   <= stb_nxt;
            wd_r    <= wd_nxt;
            wa_r    <= wa_nxt;
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    // ======================================================================
    // Outputs; read data follows the pointer, write address is latched
    assign sda_out      = 1'b0;
    assign sda_oe_out   = oe_r;
    assign wr_stb_out   = stb_r;
    assign wr_data_out  = wd_r;
    assign sub_addr_out = stb_r ? wa_r : sub_r;

endmodule : vdic_serial_slave

`default_nettype wire

// ### vdic_input_config.sv
// Input format and colour standard configuration bank of a video
// decoder, reached over the two-wire serial port.
// Assumes synchronous serial pins and an external open-drain resolver.
`timescale 1ns/1ps
`default_nettype none
`include "vdic_regs.svh"

// Overview of operation
// - Upper nibble picks autodetect or forced standard
// - Autodetect set: PAL variant, odd means pedestal
// - Forced codes map to one fixed standard
// - Bit 3 enables vertical sync processor
// - Bit 5 selects professional component input
// - Bit 6 enables horizontal sync processor
module vdic_input_config #(
    parameter logic [6:0] DEV_ADDR = 7'h20   // Arbitrary bus address
) (
    // Clock and reset
    input  wire logic                ref_clk_in,
    input  wire logic                arst_n_in,
    // Serial host port
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_out,
    // Input format to the analog front end
    output vdic_pkg::vdic_fmt_e      input_format_select_out,
    // Colour standard to the decoder core
    output logic                     std_autodetect_out,
    output logic                     auto_pal_n_out,
    output logic                     auto_ntsc_pedestal_out,
    output vdic_pkg::vdic_std_e      colour_standard_select_out,
    // Sync processing and input handling
    output logic                     vsync_processor_enable_out,
    output logic                     hsync_processor_enable_out,
    output logic                     pro_component_mode_out
);
    import vdic_pkg::*;

    // ======================================================================
    // Serial port
    logic        wr_stb;        // One-cycle write strobe
    logic [7:0]  sub_addr;      // Write address or read pointer
    logic [7:0]  wr_data;       // Written byte
    logic [7:0]  rd_data;       // Byte presented for reads

    vdic_serial_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_slave (
        .ref_clk_in   (ref_clk_in),
        .arst_n_in    (arst_n_in),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .sda_out      (sda_out),
        .sda_oe_out   (sda_oe_out),
        .wr_stb_out   (wr_stb),
        .sub_addr_out (sub_addr),
        .wr_data_out  (wr_data),
        .rd_data_in   (rd_data)
    );

    // ======================================================================
    // Register bank
    logic [7:0]  fmt_std_r,  fmt_std_nxt;   // input_format_and_standard
    logic [7:0]  vproc_r,    vproc_nxt;     // video_processing_select
    logic [3:0]  std_code;                  // Standard field of next value
    logic [3:0]  fmt_code;                  // Format field of next value

    // Write decode; reserved bits store what software writes, so they
    // read back as programmed
    always_comb begin
        fmt_std_nxt = fmt_std_r;
        vproc_nxt   = vproc_r;
        if (wr_stb && sub_addr == `VDIC_OFS_FMT_STD) begin
            fmt_std_nxt = wr_data;
        end
        if (wr_stb && sub_addr == `VDIC_OFS_VPROC) begin
            vproc_nxt = wr_data;
        end
    end

    // Read mux; unmapped subaddresses read as zero
    always_comb begin
        if (sub_addr == `VDIC_OFS_FMT_STD) begin
            rd_data = fmt_std_r;
        end else if (sub_addr == `VDIC_OFS_VPROC) begin
            rd_data = vproc_r;
        end else begin
            rd_data = `VDIC_IDLE_BYTE;
        end
    end

    // ======================================================================
    // Decode of the next register values, so outputs follow a write
    // one cycle after the strobe
    vdic_fmt_e   fmt_nxt;
    vdic_std_e   std_nxt;
    logic        auto_nxt;
    logic        paln_nxt;
    logic        ped_nxt;

    assign std_code = fmt_std_nxt[`VDIC_STD_MSB:`VDIC_STD_LSB];
    assign fmt_code = fmt_std_nxt[`VDIC_FMT_MSB:`VDIC_FMT_LSB];

    always_comb begin
        // Only three format codes are meaningful; others are flagged
        if (fmt_code == `VDIC_CODE_COMPOSITE) begin
            fmt_nxt = VDIC_FMT_COMPOSITE;
        end else if (fmt_code == `VDIC_CODE_LUMA_CHROMA) begin
            fmt_nxt = VDIC_FMT_LUMA_CHROMA;
        end else if (fmt_code == `VDIC_CODE_COMPONENT) begin
            fmt_nxt = VDIC_FMT_COMPONENT;
        end else begin
            fmt_nxt = VDIC_FMT_UNDEFINED;
        end
        // Low codes run the detector, the rest force a standard
        auto_nxt = std_code < `VDIC_STD_FORCED_MIN;
        // Autodetect set choice, held low when forced
        paln_nxt = auto_nxt & std_code[`VDIC_AUTO_PAL_N_BIT];
        ped_nxt  = auto_nxt & std_code[`VDIC_AUTO_PED_BIT];
        // Forced codes are contiguous, so the enum is an offset
        if (auto_nxt) begin
            std_nxt = VDIC_STD_AUTO;
        end else begin
            std_nxt = vdic_std_e'(std_code - `VDIC_STD_ENUM_OFFSET);
        end
    end

    // ======================================================================
    // Register update
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fmt_std_r                  <= `VDIC_RST_FMT_STD;
            vproc_r                    <= `VDIC_RST_VPROC;
            input_format_select_out    <= VDIC_FMT_COMPOSITE;
            std_autodetect_out         <= 1'b1;
            auto_pal_n_out             <= 1'b0;
            auto_ntsc_pedestal_out     <= 1'b0;
            colour_standard_select_out <= VDIC_STD_AUTO;
            vsync_processor_enable_out <= 1'b1;
            hsync_processor_enable_out <= 1'b1;
            pro_component_mode_out     <= 1'b0;
        end else begin
            fmt_std_r                  <= fmt_std_nxt;
            vproc_r                    <= vproc_nxt;
            input_format_select_out    <= fmt_nxt;
            std_autodetect_out         <= auto_nxt;
            auto_pal_n_out             <= paln_nxt;
            auto_ntsc_pedestal_out     <= ped_nxt;
            colour_standard_select_out <= std_nxt;
            vsync_processor_enable_out <= vproc_nxt[`VDIC_VSYNC_EN_BIT];
            hsync_processor_enable_out <= vproc_nxt[`VDIC_HSYNC_EN_BIT];
            pro_component_mode_out     <= vproc_nxt[`VDIC_PRO_COMP_BIT];
        end
    end

    // ======================================================================
    // Checks
    logic wr0, wr1;
    assign wr0 = wr_stb && sub_addr == `VDIC_OFS_FMT_STD;
    assign wr1 = wr_stb && sub_addr == `VDIC_OFS_VPROC;

    property p_auto_sel;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        wr0 |=> std_autodetect_out == ($past(wr_data[7:6]) == 2'h0);
    endproperty
    a_auto_sel: assert property (p_auto_sel)
        else $error("autodetect flag does not follow written code");

    property p_auto_set;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        std_autodetect_out |-> colour_standard_select_out == VDIC_STD_AUTO
            && auto_pal_n_out == fmt_std_r[5] && auto_ntsc_pedestal_out == fmt_std_r[4];
    endproperty
    a_auto_set: assert property (p_auto_set)
        else $error("autodetect set does not match standard code");

    // A forced standard leaves the autodetect set flags idle
    property p_forced_flags;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !std_autodetect_out |-> !auto_pal_n_out && !auto_ntsc_pedestal_out
            && colour_standard_select_out != VDIC_STD_AUTO;
    endproperty
    a_forced_flags: assert property (p_forced_flags)
        else $error("forced standard left autodetect flags set");

    // Registers only move on a strobe to their own subaddress
    property p_reg_hold;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !wr0 && !wr1 |=> $stable(fmt_std_r) && $stable(vproc_r);
    endproperty
    a_reg_hold: assert property (p_reg_hold)
        else $error("register changed without a write");

    property p_forced;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        wr0 && wr_data[7:4] == 4'hb |=> colour_standard_select_out == VDIC_STD_PAL_M
            ##1 colour_standard_select_out == VDIC_STD_PAL_M || $past(wr_stb);
    endproperty
    a_forced: assert property (p_forced)
        else $error("forced code did not select the matching standard");

    property p_vsync;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        wr1 |=> vsync_processor_enable_out == $past(wr_data[3]);
    endproperty
    a_vsync: assert property (p_vsync)
        else $error("vertical sync enable does not follow bit 3");

    property p_procomp;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !wr1 |=> $stable(pro_component_mode_out) && pro_component_mode_out == vproc_r[5];
    endproperty
    a_procomp: assert property (p_procomp)
        else $error("component mode changed without a write");

    property p_hsync;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        wr1 ##1 !wr1 |=> hsync_processor_enable_out == $past(wr_data[6], 2);
    endproperty
    a_hsync: assert property (p_hsync)
        else $error("horizontal sync enable does not follow bit 6");

endmodule : vdic_input_config

`default_nettype wire

// ### vdic_host_model.sv
// Host processor model: two-wire serial master for the config bank.
// Assumes sda_in is the resolved data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module vdic_host_model (
    // Clock
    input  wire logic ref_clk_in,
    // Serial pins
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    // ==========================================
    // Bit timing
    // Three cycles a phase stays clear of the two-cycle minimum
    localparam int HALF = 3;

    // Bus idle at time zero: scl high, sda released
    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : tick

    // One scl pulse; sda is sampled at the end of the high phase, just before scl falls
    task automatic pulse(output logic seen);
        tick(1);
        scl_out <= 1'b1;
        tick(HALF);
        seen = sda_in;
        scl_out <= 1'b0;
        tick(HALF);
    endtask : pulse

    // ==========================================
    // Framing
    // Start or repeated start: sda falls while scl is high
    task automatic start_c();
        sda_oe_out <= 1'b0;
        tick(1);
        scl_out <= 1'b1;
        tick(HALF);
        sda_oe_out <= 1'b1;
        tick(HALF);
        scl_out <= 1'b0;
        tick(HALF);
    endtask : start_c

    // Stop: sda rises while scl is high
    task automatic stop_c();
        sda_oe_out <= 1'b1;
        tick(1);
        scl_out <= 1'b1;
        tick(HALF);
        sda_oe_out <= 1'b0;
        tick(HALF);
    endtask : stop_c

    // MSB first, then release sda for the device's ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            sda_oe_out <= ~b[i];
            pulse(x);
        end
        sda_oe_out <= 1'b0;
        pulse(x);
        ack = ~x;
    endtask : send_byte

    // Master acks every byte but the last one
    task automatic recv_byte(output logic [7:0] b, input logic more);
        logic x;
        sda_oe_out <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i]);
        end
        sda_oe_out <= more;
        pulse(x);
    endtask : recv_byte

    // ==========================================
    // Transfers
    task automatic write_bytes(input logic [6:0] dev, input logic [7:0] sub,
                               input logic [7:0] d [$], output logic ack);
        logic a;
        start_c();
        send_byte({dev, 1'b0}, ack);
        send_byte(sub, a);
        foreach (d[i]) begin
            send_byte(d[i], a);
        end
        stop_c();
    endtask : write_bytes

    task automatic read_bytes(input logic [6:0] dev, input logic [7:0] sub,
                              input int n, output logic [7:0] q [$]);
        logic       a;
        logic [7:0] b;
        q = {};
        start_c();
        send_byte({dev, 1'b0}, a);
        send_byte(sub, a);
        start_c();
        send_byte({dev, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            recv_byte(b, i < n - 1);
            q.push_back(b);
        end
        stop_c();
    endtask : read_bytes
endmodule : vdic_host_model

`default_nettype wire

// ### vdic_input_config_tb.sv
// Self-checking bench for the input configuration bank.
// Assumes the host model drives the serial pins and sda has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module vdic_input_config_tb;
    import vdic_pkg::*;
    localparam logic [6:0] DEV = 7'h20;  // Arbitrary bus address

    logic      ref_clk;
    logic      arst_n;
    logic      scl;
    logic      host_oe;
    logic      dut_oe;
    logic      dut_sda;
    wire logic sda;
    vdic_fmt_e fmt;
    vdic_std_e cstd;
    logic      autod, paln, ped, vs, hs, pro;
    int        n_fail, total_checks;
    logic [7:0] lfsr, r0, r1;
    logic [3:0] f;
    logic       ack;
    logic [7:0] q [$];
    // Expected standard for each upper-nibble code
    vdic_std_e std_tab [16] = '{VDIC_STD_AUTO, VDIC_STD_AUTO, VDIC_STD_AUTO,
        VDIC_STD_AUTO, VDIC_STD_NTSC_J, VDIC_STD_NTSC_M, VDIC_STD_PAL_60,
        VDIC_STD_NTSC_443, VDIC_STD_PAL_BGHID, VDIC_STD_PAL_N,
        VDIC_STD_PAL_M_NOPED, VDIC_STD_PAL_M, VDIC_STD_PAL_CN,
        VDIC_STD_PAL_CN_PED, VDIC_STD_SECAM, VDIC_STD_SECAM_PED};

    // Open drain: host pulls low; the device shows its data value while
    // enabled, so a wrong value on its data pin breaks every ack and read
    assign sda = !host_oe && (dut_oe ? dut_sda : 1'b1);

    // ==========================================
    // Instances
    vdic_input_config #(.DEV_ADDR(DEV)) i_vdic_input_config (
        .ref_clk_in(ref_clk), .arst_n_in(arst_n), .scl_in(scl),
        .sda_in(sda), .sda_out(dut_sda), .sda_oe_out(dut_oe),
        .input_format_select_out(fmt), .std_autodetect_out(autod),
        .auto_pal_n_out(paln), .auto_ntsc_pedestal_out(ped),
        .colour_standard_select_out(cstd),
        .vsync_processor_enable_out(vs), .hsync_processor_enable_out(hs),
        .pro_component_mode_out(pro));

    vdic_host_model i_vdic_host_model (
        .ref_clk_in(ref_clk), .sda_in(sda), .scl_out(scl),
        .sda_oe_out(host_oe));

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // ==========================================
    // Helpers
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr_next

    // Only three format codes are defined; the rest are flagged
    function automatic vdic_fmt_e exp_fmt(input logic [3:0] c);
        case (c)
            4'h0:    return VDIC_FMT_COMPOSITE;
            4'h6:    return VDIC_FMT_LUMA_CHROMA;
            4'h9:    return VDIC_FMT_COMPONENT;
            default: return VDIC_FMT_UNDEFINED;
        endcase
    endfunction : exp_fmt

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Decoded outputs, then read-back of both registers in one burst
    task automatic check_all(input logic [7:0] e0, input logic [7:0] e1);
        logic au;
        au = (e0[7:4] < 4'h4);
        check("format", fmt, exp_fmt(e0[3:0]));
        check("autodetect", autod, au);
        check("pal_n", paln, au && e0[5]);
        check("pedestal", ped, au && e0[4]);
        check("standard", cstd, std_tab[e0[7:4]]);
        check("vsync", vs, e1[3]);
        check("pro", pro, e1[5]);
        check("hsync", hs, e1[6]);
        i_vdic_host_model.read_bytes(DEV, 8'h00, 2, q);
        check("reg0", q[0], e0);
        check("reg1", q[1], e1);
    endtask : check_all

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ==========================================
    // Main sequence
    initial begin
        arst_n = 1'b0;
        lfsr   = 8'h2c;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        r0 = 8'h00;
        r1 = 8'hc8;
        check_all(r0, r1);
        // Every standard code, format codes cycling with a random one
        for (int s = 0; s < 16; s++) begin
            lfsr = lfsr_next(lfsr);
            f = (s % 4 == 0) ? 4'h0 : (s % 4 == 1) ? 4'h6 : (s % 4 == 2) ? 4'h9
              : lfsr[3:0];
            r0 = {s[3:0], f};
            i_vdic_host_model.write_bytes(DEV, 8'h00, {r0}, ack);
            check("ack", ack, 1'b1);
            check_all(r0, r1);
        end
        // Second register: all off, all on, then random, reserved at default
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            r1 = (i == 0) ? 8'h80 : (i == 1) ? 8'he8 : (8'h80 | (lfsr & 8'h68));
            i_vdic_host_model.write_bytes(DEV, 8'h01, {r1}, ack);
            check_all(r0, r1);
        end
        // Both registers back to back through auto-increment
        r0 = lfsr_next(lfsr);
        r1 = 8'h80 | (r0 & 8'h68);
        i_vdic_host_model.write_bytes(DEV, 8'h00, {r0, r1}, ack);
        check_all(r0, r1);
        // Unmapped place is ignored on write and reads as zero
        i_vdic_host_model.write_bytes(DEV, 8'h02, {8'hff}, ack);
        i_vdic_host_model.read_bytes(DEV, 8'h02, 1, q);
        check("unmapped", q[0], 8'h00);
        // Another device address gets no ack and changes nothing
        i_vdic_host_model.write_bytes(DEV ^ 7'h01, 8'h00, {~r0}, ack);
        check("foreign ack", ack, 1'b0);
        check_all(r0, r1);
        // Reset in mid-run restores the defaults
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check_all(8'h00, 8'hc8);
        wrap_up();
    end

    // Watchdog: the sequence needs some 14400 cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        $display("unexpected watchdog: expected done seen hang");
        wrap_up();
    end
endmodule : vdic_input_config_tb

`default_nettype wire
